// ===== design/cocfg_apply.sv
`timescale 1ns/100ps
module cocfg_apply
   import cocfg_pkg::*;
(
   input wire logic i_extended_mode,
   input wire cocfg_ctrl_t i_reg_ctrl,
   input wire logic i_output_swing_pin,
   input wire logic i_output_edge_pin,
   output cocfg_ctrl_t o_eff_ctrl,
   output logic o_data_on_both_edges
);
   // ==========================================================
   // Mode selection
   cocfg_ctrl_t sel;
   always_comb begin
      if (i_extended_mode) begin
         sel = i_reg_ctrl; // RULE_02
      end else begin
         sel = CTRL_RESET; // RULE_02
         sel.output_swing_select = i_output_swing_pin; // RULE_10
         sel.output_edge_select = i_output_edge_pin; // RULE_10
      end
      o_eff_ctrl = sel; // RULE_04 RULE_08
      // Phase only matters in double rate
      o_eff_ctrl.double_rate_clock_phase =
         sel.double_rate_clock_phase & ~sel.double_rate_disable; // RULE_05
      // Edge only matters in single rate
      o_eff_ctrl.output_edge_select =
         sel.output_edge_select & sel.double_rate_disable; // RULE_07 RULE_09
      o_data_on_both_edges = ~sel.double_rate_disable; // RULE_06
   end
endmodule // cocfg_apply

// ===== design/cocfg_pkg.sv
package cocfg_pkg;
   // ==========================================================
   // Serial frame layout
   localparam int HDR_BITS = 8;
   localparam logic [HDR_BITS-1:0] HDR_PATTERN = 8'hA5;
   localparam int ADDR_BITS = 4;
   localparam int DATA_BITS = 16;
   localparam logic [4:0] CNT_ZERO = 5'h00;
   localparam logic [4:0] CNT_ONE = 5'h01;
   localparam logic [4:0] HDR_LAST = 5'h07;
   localparam logic [4:0] ADDR_LAST = 5'h03;
   localparam logic [4:0] DATA_LAST = 5'h0F;

   // ==========================================================
   // Register map
   localparam logic [3:0] ADDR_OUTPUT_CONFIGURATION = 4'h1;
   localparam logic [15:0] OUTPUT_CONFIGURATION_RESET = 16'hB2FF;
   localparam logic [15:0] OUTPUT_CONFIGURATION_FIXED = 16'hA0FF;
   localparam int BIT_DUTY_STABILIZER = 12;
   localparam int BIT_CLOCK_PHASE = 11;
   localparam int BIT_DOUBLE_RATE_DISABLE = 10;
   localparam int BIT_OUTPUT_SWING = 9;
   localparam int BIT_OUTPUT_EDGE = 8;

   // ==========================================================
   // Control bits
   typedef struct packed {
      logic duty_stabilizer_enable;
      logic double_rate_clock_phase;
      logic double_rate_disable;
      logic output_swing_select;
      logic output_edge_select;
   } cocfg_ctrl_t;

   localparam cocfg_ctrl_t CTRL_RESET = '{
      duty_stabilizer_enable: 1'b1,
      double_rate_clock_phase: 1'b0,
      double_rate_disable: 1'b0,
      output_swing_select: 1'b1,
      output_edge_select: 1'b0
   };

   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_HDR = 6'b000010,
      ST_ADDR = 6'b000100,
      ST_DATA = 6'b001000,
      ST_DONE = 6'b010000,
      ST_BAD = 6'b100000
   } cocfg_state_t;
endpackage

// ===== design/cocfg_top.sv
`timescale 1ns/100ps
// Function
// [RULE_01] Host sends 4-bit address MSB first right after the header.
// [RULE_02] Register contents apply only in extended control mode.
// [RULE_03] Power-on reset gives configuration value 0xB2FF.
// [RULE_04] Duty stabilizer bit 1 enables stabilization, 0 bypasses; reset 1.
// [RULE_05] Clock phase bit acts only in double rate; 1 means 90 degrees.
// [RULE_06] Double-rate disable 0 outputs data on both clock edges.
// [RULE_07] Double-rate disable 1 gives single rate, edge chosen by edge bit.
// [RULE_08] Swing bit 1 selects 710 mV, 0 selects 510 mV; reset 1.
// [RULE_09] Single rate edge bit 1 rising edge, 0 falling edge; reset 0.
// [RULE_10] Normal mode takes edge and swing from pins, extended from bits; code holds edge select at 0 in normal mode, since double rate stays on.
// [RULE_11] Host writes fixed bits 15,13,7:0 as 1 and bit 14 as 0.
module cocfg_top
   import cocfg_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_extended_mode,
   input wire logic i_serial_select_n,
   input wire logic i_serial_clock,
   input wire logic i_serial_data,
   input wire logic i_output_swing_pin,
   input wire logic i_output_edge_pin,
   output logic o_duty_stabilizer_enable,
   output logic o_double_rate_clock_phase,
   output logic o_double_rate_disable,
   output logic o_output_swing_select,
   output logic o_output_edge_select,
   output logic o_data_on_both_edges,
   output logic [15:0] o_config_word,
   output logic o_write_strobe,
   output logic o_frame_error
);
   // ==========================================================
   // Helpers
   function automatic logic [15:0] shift_in(input logic [15:0] cur,
                                           input logic bit_in);
      shift_in = {cur[14:0], bit_in};
   endfunction

   function automatic logic [15:0] pack_word(input cocfg_ctrl_t c);
      logic [15:0] w;
      w = OUTPUT_CONFIGURATION_FIXED;
      w[BIT_DUTY_STABILIZER] = c.duty_stabilizer_enable;
      w[BIT_CLOCK_PHASE] = c.double_rate_clock_phase;
      w[BIT_DOUBLE_RATE_DISABLE] = c.double_rate_disable;
      w[BIT_OUTPUT_SWING] = c.output_swing_select;
      w[BIT_OUTPUT_EDGE] = c.output_edge_select;
      pack_word = w;
   endfunction

   // ==========================================================
   // Serial edge detection
   logic sclk_prev;
   logic sel_prev_n;
   logic next_sclk_prev;
   logic next_sel_prev_n;
   logic sclk_rise;
   logic frame_end;

   always_comb begin
      next_sclk_prev = i_serial_clock;
      next_sel_prev_n = i_serial_select_n;
      sclk_rise = i_serial_clock & ~sclk_prev & ~i_serial_select_n;
      frame_end = i_serial_select_n & ~sel_prev_n;
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         sclk_prev <= 1'b0;
         sel_prev_n <= 1'b1;
      end else begin
         sclk_prev <= next_sclk_prev;
         sel_prev_n <= next_sel_prev_n;
      end
   end

   // ==========================================================
   // Frame receiver
   cocfg_state_t state;
   cocfg_state_t next_state;
   logic [4:0] bit_cnt;
   logic [4:0] next_bit_cnt;
   logic [15:0] shreg;
   logic [15:0] next_shreg;
   logic [ADDR_BITS-1:0] addr;
   logic [ADDR_BITS-1:0] next_addr;
   logic do_write;
   logic bad_frame;

   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_addr = addr;
      do_write = 1'b0;
      bad_frame = 1'b0;
      case (state)
         ST_IDLE: begin
            next_bit_cnt = CNT_ZERO;
            next_shreg = '0;
            if (!i_serial_select_n) begin
               next_state = ST_HDR;
            end
         end
         ST_HDR: begin
            if (sclk_rise) begin
               next_shreg = shift_in(shreg, i_serial_data);
               next_bit_cnt = bit_cnt + CNT_ONE;
               if (bit_cnt == HDR_LAST) begin
                  next_bit_cnt = CNT_ZERO;
                  if (next_shreg[HDR_BITS-1:0] == HDR_PATTERN) begin
                     next_state = ST_ADDR;
                  end else begin
                     next_state = ST_BAD;
                     bad_frame = 1'b1;
                  end
               end
            end
         end
         ST_ADDR: begin
            if (sclk_rise) begin
               // Address shifts in MSB first
               next_addr = {addr[ADDR_BITS-2:0], i_serial_data}; // RULE_01
               next_bit_cnt = bit_cnt + CNT_ONE;
               if (bit_cnt == ADDR_LAST) begin
                  next_bit_cnt = CNT_ZERO;
                  next_state = ST_DATA;
               end
            end
         end
         ST_DATA: begin
            if (sclk_rise) begin
               next_shreg = shift_in(shreg, i_serial_data);
               next_bit_cnt = bit_cnt + CNT_ONE;
               if (bit_cnt == DATA_LAST) begin
                  next_bit_cnt = CNT_ZERO;
                  next_state = ST_DONE;
                  do_write = (addr == ADDR_OUTPUT_CONFIGURATION);
               end
            end
         end
         ST_DONE: begin
            if (sclk_rise) begin
               next_state = ST_BAD;
               bad_frame = 1'b1;
            end
         end
         ST_BAD: begin
            next_state = ST_BAD;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      // Short frame
      if (frame_end && (state == ST_HDR || state == ST_ADDR ||
                        state == ST_DATA)) begin
         bad_frame = 1'b1;
      end
      if (i_serial_select_n) begin
         next_state = ST_IDLE;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         state <= ST_IDLE;
         bit_cnt <= CNT_ZERO;
         shreg <= '0;
         addr <= '0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         addr <= next_addr;
      end
   end

   // ==========================================================
   // Configuration register
   cocfg_ctrl_t cfg;
   cocfg_ctrl_t next_cfg;
   logic next_write_strobe;
   logic next_frame_error;

   always_comb begin
      next_cfg = cfg;
      if (do_write) begin
         next_cfg.duty_stabilizer_enable =
            next_shreg[BIT_DUTY_STABILIZER]; // RULE_04
         next_cfg.double_rate_clock_phase =
            next_shreg[BIT_CLOCK_PHASE]; // RULE_05
         next_cfg.double_rate_disable =
            next_shreg[BIT_DOUBLE_RATE_DISABLE]; // RULE_06 RULE_07
         next_cfg.output_swing_select =
            next_shreg[BIT_OUTPUT_SWING]; // RULE_08
         next_cfg.output_edge_select =
            next_shreg[BIT_OUTPUT_EDGE]; // RULE_09
      end
      next_write_strobe = do_write;
      next_frame_error = bad_frame;
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         cfg <= CTRL_RESET; // RULE_03
         o_write_strobe <= 1'b0;
         o_frame_error <= 1'b0;
      end else begin
         cfg <= next_cfg;
         o_write_strobe <= next_write_strobe;
         o_frame_error <= next_frame_error;
      end
   end

   // ==========================================================
   // Effective settings
   cocfg_ctrl_t eff;
   logic both_edges;

   cocfg_apply u_apply (
      .i_extended_mode(i_extended_mode),
      .i_reg_ctrl(cfg),
      .i_output_swing_pin(i_output_swing_pin),
      .i_output_edge_pin(i_output_edge_pin),
      .o_eff_ctrl(eff),
      .o_data_on_both_edges(both_edges)
   );

   logic [15:0] next_config_word;
   always_comb begin
      next_config_word = pack_word(cfg); // RULE_03
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_duty_stabilizer_enable <= CTRL_RESET.duty_stabilizer_enable;
         o_double_rate_clock_phase <= CTRL_RESET.double_rate_clock_phase;
         o_double_rate_disable <= CTRL_RESET.double_rate_disable;
         o_output_swing_select <= CTRL_RESET.output_swing_select;
         o_output_edge_select <= CTRL_RESET.output_edge_select;
         o_data_on_both_edges <= ~CTRL_RESET.double_rate_disable;
         o_config_word <= OUTPUT_CONFIGURATION_RESET;
      end else begin
         o_duty_stabilizer_enable <= eff.duty_stabilizer_enable; // RULE_04
         o_double_rate_clock_phase <= eff.double_rate_clock_phase; // RULE_05
         o_double_rate_disable <= eff.double_rate_disable; // RULE_07
         o_output_swing_select <= eff.output_swing_select; // RULE_10
         o_output_edge_select <= eff.output_edge_select; // RULE_10
         o_data_on_both_edges <= both_edges; // RULE_06
         o_config_word <= next_config_word;
      end
   end
endmodule // cocfg_top

// ===== tb/cocfg_chk.sv
`timescale 1ns/100ps
module cocfg_chk (
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_extended_mode,
   input wire logic i_output_swing_pin,
   input wire logic o_duty_stabilizer_enable,
   input wire logic o_double_rate_clock_phase,
   input wire logic o_double_rate_disable,
   input wire logic o_output_swing_select,
   input wire logic o_output_edge_select,
   input wire logic o_data_on_both_edges,
   input wire logic [15:0] o_config_word,
   input wire logic o_write_strobe,
   input wire logic o_frame_error
);
   // ==========
   // Port relations
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);
   AST_RESET_VALUE: assert property (
      $fell(i_sys_rst) |-> o_config_word == 16'hB2FF && o_output_swing_select
      && o_duty_stabilizer_enable && !o_double_rate_disable)
      else $error("defaults missing after reset");
   AST_FIXED_BITS: assert property (
      (o_config_word & 16'hE0FF) == 16'hA0FF)
      else $error("fixed bits wrong");
   AST_WORD_ON_WRITE: assert property (
      !$stable(o_config_word) && !$past(i_sys_rst) |-> $past(o_write_strobe))
      else $error("config changed without write");
   AST_PHASE_SDR: assert property (
      o_double_rate_disable |-> !o_double_rate_clock_phase)
      else $error("phase active in single rate");
   AST_EDGE_DDR: assert property (
      !o_double_rate_disable |-> !o_output_edge_select)
      else $error("edge select active in double rate");
   AST_BOTH_EDGES: assert property (
      o_data_on_both_edges == !o_double_rate_disable)
      else $error("both edge flag wrong");
   AST_NORMAL_PINS: assert property (
      !i_extended_mode ##1 !i_extended_mode
      |-> o_output_swing_select == $past(i_output_swing_pin))
      else $error("swing not from pin");
   AST_NORMAL_FIXED: assert property (
      !i_extended_mode ##1 !i_extended_mode
      |-> o_duty_stabilizer_enable && !o_double_rate_disable)
      else $error("register applied in normal mode");
   AST_EXT_APPLY: assert property (
      i_extended_mode ##1 i_extended_mode |-> o_duty_stabilizer_enable
      == o_config_word[12] && o_double_rate_disable == o_config_word[10]
      && o_output_swing_select == o_config_word[9])
      else $error("register not applied");
   COV_WRITE: cover property (o_write_strobe);
   COV_ERROR: cover property (o_frame_error);
   COV_SDR_RISE: cover property (
      o_double_rate_disable && o_output_edge_select);
endmodule // cocfg_chk

bind cocfg_top cocfg_chk chk (.i_mclk, .i_sys_rst, .i_extended_mode,
   .i_output_swing_pin, .o_duty_stabilizer_enable, .o_double_rate_clock_phase,
   .o_double_rate_disable, .o_output_swing_select, .o_output_edge_select,
   .o_data_on_both_edges, .o_config_word, .o_write_strobe, .o_frame_error);

// ===== tb/cocfg_host.sv
`timescale 1ns/100ps
module cocfg_host (
   input wire logic i_mclk,
   output logic o_sel_n,
   output logic o_sclk,
   output logic o_sdata
);
   // ==========
   // Serial host, clock idles low
   initial begin
      o_sel_n = 1'b1;
      o_sclk = 1'b0;
      o_sdata = 1'b0;
   end
   // Released data line never shows a stale bit
   always @(posedge i_mclk) if (o_sel_n) o_sdata <= ~o_sdata;
   task automatic send(input logic [31:0] f, input int n);
      @(posedge i_mclk) o_sel_n <= 1'b0;
      for (int k = 31; k > 31 - n; k--) begin
         @(posedge i_mclk) o_sdata <= f[k];
         @(posedge i_mclk) o_sclk <= 1'b1;
         @(posedge i_mclk) o_sclk <= 1'b0;
      end
      @(posedge i_mclk) o_sel_n <= 1'b1;
   endtask
endmodule // cocfg_host

// ===== tb/tb_cocfg_top.sv
`timescale 1ns/100ps
module tb_cocfg_top;
   import cocfg_pkg::*;
   logic i_mclk, i_sys_rst, i_extended_mode, sw_pin, edge_pin;
   logic sel_n, sclk, sdata, stab, phase, dis, swing, edge_sel;
   logic both, wstb, ferr;
   logic [15:0] word, w;
   logic [31:0] seed = 32'hFC023B5A;
   int bad_count = 0, num_checks = 0, n_wr = 0, n_err = 0, e_wr = 0, e_err = 0;
   cocfg_host host (.i_mclk, .o_sel_n(sel_n), .o_sclk(sclk), .o_sdata(sdata));
   cocfg_top uut (.i_mclk, .i_sys_rst, .i_extended_mode,
      .i_serial_select_n(sel_n), .i_serial_clock(sclk), .i_serial_data(sdata),
      .i_output_swing_pin(sw_pin), .i_output_edge_pin(edge_pin),
      .o_duty_stabilizer_enable(stab), .o_double_rate_clock_phase(phase),
      .o_double_rate_disable(dis), .o_output_swing_select(swing),
      .o_output_edge_select(edge_sel), .o_data_on_both_edges(both),
      .o_config_word(word), .o_write_strobe(wstb), .o_frame_error(ferr));
   // ==========
   // Clock, counters, helpers
   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end
   always @(posedge i_mclk) begin
      if (wstb === 1'b1) n_wr++;
      if (ferr === 1'b1) n_err++;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic compare(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_all();
      logic [15:0] e;
      #1;
      compare(word, w);
      if (i_extended_mode)
         e = {10'h000, w[12], ~w[10] & w[11], w[10], w[9],
            w[10] & w[8], ~w[10]};
      else
         e = {10'h000, 1'b1, 2'b00, sw_pin, 2'b01};
      compare({10'h0, stab, phase, dis, swing, edge_sel, both}, e);
   endtask
   task automatic frame(input logic [7:0] h, input logic [3:0] a,
         input logic [15:0] dd, input int n);
      logic [31:0] r;
      r = rnd();
      @(posedge i_mclk) {sw_pin, edge_pin} <= r[1:0];
      host.send({h, a, dd, 4'h0}, n);
      if (h === HDR_PATTERN && a === 4'h1 && n >= 28) begin
         e_wr++;
         w = (dd & 16'h1F00) | OUTPUT_CONFIGURATION_FIXED;
      end
      // Bad header, short frame or extra bits each give one error pulse
      if (h !== HDR_PATTERN || n != 28) e_err++;
      repeat (3) @(posedge i_mclk);
      check_all();
   endtask
   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ==========
   // Scenarios
   initial begin
      i_sys_rst = 1'b1;
      i_extended_mode = 1'b1;
      sw_pin = 1'b0;
      edge_pin = 1'b0;
      w = OUTPUT_CONFIGURATION_RESET;
      repeat (3) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      check_all();
      for (int i = 0; i < 32; i++)
         frame(HDR_PATTERN, 4'h1, 16'hA0FF | 16'(i << 8), 28);
      frame(HDR_PATTERN, 4'h8, 16'hB0FF, 28);
      frame(HDR_PATTERN, 4'hE, 16'hA1FF, 28);
      frame(~HDR_PATTERN, 4'h1, 16'hA2FF, 28);
      frame(HDR_PATTERN, 4'h1, 16'hA3FF, 20);
      frame(HDR_PATTERN, 4'h1, 16'hB3FF, 30);
      @(posedge i_mclk) i_extended_mode <= 1'b0;
      for (int i = 0; i < 8; i++)
         frame(HDR_PATTERN, 4'h1,
            (16'(rnd()) | 16'hA0FF) & 16'hBFFF, 28);
      @(posedge i_mclk) i_extended_mode <= 1'b1;
      repeat (2) @(posedge i_mclk);
      check_all();
      // Mid-run reset must bring back the defaults
      @(posedge i_mclk) i_sys_rst <= 1'b1;
      repeat (3) @(posedge i_mclk);
      i_sys_rst <= 1'b0;
      w = OUTPUT_CONFIGURATION_RESET;
      check_all();
      frame(HDR_PATTERN, 4'h1, 16'hA6FF, 28);
      compare(16'(n_wr), 16'(e_wr));
      compare(16'(n_err), 16'(e_err));
      complete_run();
   end
   initial begin
      #500000;
      bad_count++;
      complete_run();
   end
endmodule // tb_cocfg_top
